// ### src/arp_regs.vh
// Register offsets, field positions, reset values and codes of the converter control block.
`ifndef ARP_REGS_VH
`define ARP_REGS_VH
`define ARP_PRINTED_P4CFG    8'hAE
`define ARP_PRINTED_P12CFG   8'hAF
`define ARP_PRINTED_REFSEL   8'hB0
`define ARP_OFF_P4CFG        12'h2B8
`define ARP_OFF_P12CFG       12'h2BC
`define ARP_OFF_REFSEL       12'h2C0
`define ARP_OFF_CTRL         12'h2C4
`define ARP_OFF_TIMING       12'h2C8
`define ARP_OFF_RESULT       12'h2CC
`define ARP_REFSEL_EXT_BIT   7
`define ARP_REFSEL_MASK      8'h83
`define ARP_P12_MASK         8'hC3
`define ARP_CTRL_GO_BIT      6
`define ARP_CTRL_EOC_BIT     5
`define ARP_CTRL_GCH_BIT     4
`define ARP_TIM_RES_BIT      2
`define ARP_RST_BYTE         8'h00
`define ARP_REF_EXT          2'h3
`define ARP_REF_VDD          2'h2
`define ARP_REF_3V5          2'h1
`define ARP_REF_2V5          2'h0
`define ARP_DIV_16           2'h0
`define ARP_DIV_8            2'h1
`define ARP_DIV_1            2'h2
`define ARP_DIV_2            2'h3
`define ARP_PER_12BIT        8'h10
`define ARP_PER_8BIT         8'h0C
`define ARP_CLK_PER_PERIOD   8'h04
`define ARP_RESP_OKAY        2'h0
`define ARP_RESP_SLVERR      2'h2
`endif

// ### src/arp_clk_div.v
// Converter clock enable divider.
`timescale 1ns/100ps
module arp_clk_div (
    input  wire       aclk,      // System clock.
    input  wire       aresetn,   // Synchronous reset, active low.
    input  wire       run,       // Divider counts while high.
    input  wire [1:0] divsel,    // Divide code.
    output reg        conv_tick  // One-cycle converter clock enable.
);
`include "arp_regs.vh"
    reg [3:0] cnt_ff;
    reg [3:0] lim;
    always @* begin
        case (divsel)
            `ARP_DIV_16: lim = 4'hF;
            `ARP_DIV_8:  lim = 4'h7;
            `ARP_DIV_1:  lim = 4'h0;
            default:     lim = 4'h1;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_ff    <= 4'h0;
            conv_tick <= 1'b0;
        end else if (cnt_ff >= lim) begin
            cnt_ff    <= 4'h0;
            conv_tick <= 1'b1;
        end else begin
            cnt_ff    <= cnt_ff + 4'h1;
            conv_tick <= 1'b0;
        end
    end
endmodule // arp_clk_div

// ### src/arp_seq.v
// Conversion length sequencer counting converter clock ticks.
`timescale 1ns/100ps
module arp_seq (
    input  wire       aclk,      // System clock.
    input  wire       aresetn,   // Synchronous reset, active low.
    input  wire       start,     // One-cycle start pulse.
    input  wire       res12,     // Live resolution bit sampled at start, 1 means 12-bit.
    input  wire       conv_tick, // Converter clock enable.
    output reg        busy,      // Conversion in progress.
    output reg        done       // One-cycle completion pulse.
);
`include "arp_regs.vh"
    reg [7:0] left_ff;
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy    <= 1'b0;
            done    <= 1'b0;
            left_ff <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy    <= 1'b1;
                left_ff <= res12 ? `ARP_PER_12BIT * `ARP_CLK_PER_PERIOD
                                 : `ARP_PER_8BIT * `ARP_CLK_PER_PERIOD;
            end else if (busy && conv_tick) begin
                if (left_ff == 8'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                left_ff <= left_ff - 8'h01;
            end
        end
    end
endmodule // arp_seq

// ### src/arp_top.v
// Converter reference, timing and pin control behind an AXI4-Lite slave.
`timescale 1ns/100ps
module arp_top (
    input  wire        aclk,          // System clock.
    input  wire        aresetn,       // Synchronous reset, active low.
    input  wire [11:0] s_axi_awaddr,  // Write address.
    input  wire        s_axi_awvalid, // Write address valid.
    output reg         s_axi_awready, // Write address ready.
    input  wire [31:0] s_axi_wdata,   // Write data.
    input  wire [3:0]  s_axi_wstrb,   // Write strobes.
    input  wire        s_axi_wvalid,  // Write data valid.
    output reg         s_axi_wready,  // Write data ready.
    output reg  [1:0]  s_axi_bresp,   // Write response.
    output reg         s_axi_bvalid,  // Write response valid.
    input  wire        s_axi_bready,  // Write response ready.
    input  wire [11:0] s_axi_araddr,  // Read address.
    input  wire        s_axi_arvalid, // Read address valid.
    output reg         s_axi_arready, // Read address ready.
    output reg  [31:0] s_axi_rdata,   // Read data.
    output reg  [1:0]  s_axi_rresp,   // Read response.
    output reg         s_axi_rvalid,  // Read data valid.
    input  wire        s_axi_rready,  // Read data ready.
    input  wire [11:0] core_result,   // Raw converter core result.
    input  wire        core_over,     // Input above high reference.
    input  wire        core_under,    // Input below low reference.
    output reg  [1:0]  ref_route,     // Reference mux code.
    output reg         ext_ref_pin_en, // Port 4 pin 0 is reference input.
    output reg  [12:0] chan_onehot,   // Channel connect, one bit a channel.
    output reg         conv_clk_en,   // Converter clock enable pulse.
    output reg         conv_active,   // Conversion in progress.
    output reg         conv_res12,    // Latched resolution.
    output reg  [7:0]  p4_dig_off,    // Port 4 digital isolate.
    output reg  [1:0]  p1_dig_off,    // Port 1 pins 7,6 digital isolate.
    output reg  [1:0]  p2_dig_off     // Port 2 pins 1,0 digital isolate.
);
`include "arp_regs.vh"
    reg [7:0]  port4_analog_config_ff;
    reg [7:0]  port12_analog_config_ff;
    reg [7:0]  reference_select_ff;
    reg        convert_go_ff;
    reg        eoc_ff;
    reg        channel_global_enable_ff;
    reg [3:0]  channel_select_ff;
    reg [1:0]  converter_clock_divsel_ff;
    reg        resolution_select_ff;
    reg [11:0] result_ff;
    reg [7:0]  lat_ref_ff;
    reg [1:0]  lat_div_ff;
    reg        lat_res_ff;
    reg        aw_got_ff;
    reg        w_got_ff;
    reg [11:0] aw_addr_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;
    reg        start_ff;
    reg [1:0]  nxt_ref_route;
    reg [12:0] nxt_chan;
    wire       tick;
    wire       busy;
    wire       done;
    wire       wr_fire;
    wire [11:0] sat_result;

    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

    arp_clk_div u_div (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (busy),
        .divsel    (lat_div_ff),
        .conv_tick (tick)
    );

    // The sequencer loads its length on the same edge that fills the latch,
    // so it must read the live resolution bit, not the latch.
    arp_seq u_seq (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (start_ff),
        .res12     (resolution_select_ff),
        .conv_tick (tick),
        .busy      (busy),
        .done      (done)
    );

    // Write channel: address and data taken in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ARP_RESP_OKAY;
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            aw_addr_ff    <= 12'h000;
            w_data_ff     <= 32'h00000000;
            w_strb_ff     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff     <= 1'b1;
                aw_addr_ff    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff     <= 1'b1;
                w_data_ff    <= s_axi_wdata;
                w_strb_ff    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_ff == `ARP_OFF_P4CFG ||
                    aw_addr_ff == `ARP_OFF_P12CFG ||
                    aw_addr_ff == `ARP_OFF_REFSEL ||
                    aw_addr_ff == `ARP_OFF_CTRL ||
                    aw_addr_ff == `ARP_OFF_TIMING ||
                    aw_addr_ff == `ARP_OFF_RESULT)
                    s_axi_bresp <= `ARP_RESP_OKAY;
                else
                    s_axi_bresp <= `ARP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_ff     <= 1'b0;
                w_got_ff      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register file; only byte lane 0 carries data.
    always @(posedge aclk) begin
        if (!aresetn) begin
            port4_analog_config_ff    <= `ARP_RST_BYTE;
            port12_analog_config_ff   <= `ARP_RST_BYTE;
            reference_select_ff       <= `ARP_RST_BYTE;
            convert_go_ff             <= 1'b0;
            eoc_ff                    <= 1'b0;
            channel_global_enable_ff  <= 1'b0;
            channel_select_ff         <= 4'h0;
            converter_clock_divsel_ff <= `ARP_DIV_16;
            resolution_select_ff      <= 1'b0;
            start_ff                  <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (wr_fire && w_strb_ff[0]) begin
                if (aw_addr_ff == `ARP_OFF_P4CFG) begin
                    port4_analog_config_ff <= w_data_ff[7:0];
                end else if (aw_addr_ff == `ARP_OFF_P12CFG) begin
                    port12_analog_config_ff <= w_data_ff[7:0]
                                             & `ARP_P12_MASK;
                end else if (aw_addr_ff == `ARP_OFF_REFSEL) begin
                    reference_select_ff <= w_data_ff[7:0]
                                         & `ARP_REFSEL_MASK;
                end else if (aw_addr_ff == `ARP_OFF_CTRL) begin
                    channel_global_enable_ff <=
                        w_data_ff[`ARP_CTRL_GCH_BIT];
                    channel_select_ff <= w_data_ff[3:0];
                    if (w_data_ff[`ARP_CTRL_GO_BIT] && !busy) begin
                        convert_go_ff <= 1'b1;
                        eoc_ff        <= 1'b0;
                        start_ff      <= 1'b1;
                    end else if (!w_data_ff[`ARP_CTRL_EOC_BIT]) begin
                        eoc_ff <= eoc_ff & ~done;
                    end
                end else if (aw_addr_ff == `ARP_OFF_TIMING) begin
                    converter_clock_divsel_ff <= w_data_ff[1:0];
                    resolution_select_ff <= w_data_ff[`ARP_TIM_RES_BIT];
                end
            end
            // Completion sets the flag over any software clear.
            if (done) begin
                convert_go_ff <= 1'b0;
                eoc_ff        <= 1'b1;
            end
        end
    end

    // Settings latched at start and held through the conversion.
    always @(posedge aclk) begin
        if (!aresetn) begin
            lat_ref_ff <= `ARP_RST_BYTE;
            lat_div_ff <= `ARP_DIV_16;
            lat_res_ff <= 1'b0;
            result_ff  <= 12'h000;
        end else begin
            if (start_ff) begin
                lat_ref_ff <= reference_select_ff;
                lat_div_ff <= converter_clock_divsel_ff;
                lat_res_ff <= resolution_select_ff;
            end
            if (done)
                result_ff <= sat_result;
        end
    end

    assign sat_result = core_over  ? 12'hFFF :
                        core_under ? 12'h000 : core_result;

    // Reference route and channel decode.
    always @* begin
        if (lat_ref_ff[`ARP_REFSEL_EXT_BIT])
            nxt_ref_route = `ARP_REF_EXT;
        else if (lat_ref_ff[1])
            nxt_ref_route = `ARP_REF_VDD;
        else if (lat_ref_ff[0])
            nxt_ref_route = `ARP_REF_3V5;
        else
            nxt_ref_route = `ARP_REF_2V5;
        nxt_chan = 13'h0000;
        if (channel_global_enable_ff && channel_select_ff <= 4'hC)
            nxt_chan[channel_select_ff] = 1'b1;
        if (reference_select_ff[`ARP_REFSEL_EXT_BIT])
            nxt_chan[0] = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ref_route      <= `ARP_REF_2V5;
            ext_ref_pin_en <= 1'b0;
            chan_onehot    <= 13'h0000;
            conv_clk_en    <= 1'b0;
            conv_active    <= 1'b0;
            conv_res12     <= 1'b0;
            p4_dig_off     <= `ARP_RST_BYTE;
            p1_dig_off     <= 2'h0;
            p2_dig_off     <= 2'h0;
        end else begin
            ref_route      <= nxt_ref_route;
            ext_ref_pin_en <= reference_select_ff[`ARP_REFSEL_EXT_BIT];
            chan_onehot    <= nxt_chan;
            conv_clk_en    <= tick;
            conv_active    <= busy;
            conv_res12     <= lat_res_ff;
            p4_dig_off     <= port4_analog_config_ff;
            p1_dig_off     <= port12_analog_config_ff[7:6];
            p2_dig_off     <= port12_analog_config_ff[1:0];
        end
    end

    // Read channel; analog config registers are write-only and read zero.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ARP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `ARP_RESP_OKAY;
            if (s_axi_araddr == `ARP_OFF_REFSEL) begin
                s_axi_rdata <= {24'h000000, reference_select_ff};
            end else if (s_axi_araddr == `ARP_OFF_CTRL) begin
                s_axi_rdata <= {25'h0000000, convert_go_ff, eoc_ff,
                                channel_global_enable_ff,
                                channel_select_ff};
            end else if (s_axi_araddr == `ARP_OFF_TIMING) begin
                s_axi_rdata <= {29'h0000000, resolution_select_ff,
                                converter_clock_divsel_ff};
            end else if (s_axi_araddr == `ARP_OFF_RESULT) begin
                s_axi_rdata <= {20'h00000, result_ff};
            end else if (s_axi_araddr == `ARP_OFF_P4CFG ||
                         s_axi_araddr == `ARP_OFF_P12CFG) begin
                s_axi_rdata <= 32'h00000000;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `ARP_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // arp_top

// ### test/arp_chk_assertions.sv
// Assertion checker for the converter control block.
`timescale 1ns/100ps
module arp_chk (
    input wire        aclk,           // Clock.
    input wire        aresetn,        // Reset, active low.
    input wire        s_axi_awvalid,  // Write address valid.
    input wire        s_axi_awready,  // Write address ready.
    input wire        s_axi_wvalid,   // Write data valid.
    input wire        s_axi_wready,   // Write data ready.
    input wire        s_axi_bvalid,   // Write response valid.
    input wire        s_axi_arvalid,  // Read address valid.
    input wire        s_axi_arready,  // Read address ready.
    input wire        s_axi_rvalid,   // Read data valid.
    input wire [1:0]  ref_route,      // Reference mux code.
    input wire        ext_ref_pin_en, // External reference pin.
    input wire [12:0] chan_onehot,    // Channel connect.
    input wire        conv_clk_en,    // Converter tick.
    input wire        conv_active,    // Conversion running.
    input wire        conv_res12      // Latched resolution.
);
    reg  [7:0] tk_ff;
    wire [7:0] nxt_tk = conv_active ? tk_ff + {7'h00, conv_clk_en} : 8'h00;
    always @(posedge aclk) begin
        if (!aresetn) tk_ff <= 8'h00;
        else tk_ff <= nxt_tk;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_EXT_CH0: assert property (
        ext_ref_pin_en && $past(ext_ref_pin_en) |-> !chan_onehot[0])
        else $error("channel zero connected while used as reference");
    AST_ONE_CHAN: assert property ($onehot0(chan_onehot))
        else $error("more than one channel connected");
    AST_REF_HOLD: assert property (
        conv_active && $past(conv_active, 2) |-> $stable(ref_route))
        else $error("reference changed during conversion");
    AST_RES_HOLD: assert property (
        conv_active && $past(conv_active, 2) |-> $stable(conv_res12))
        else $error("resolution changed during conversion");
    AST_CONV_LEN: assert property (
        $fell(conv_active) && $past(aresetn) |-> (conv_res12 ?
        (tk_ff >= 8'h3F && tk_ff <= 8'h41) : (tk_ff >= 8'h2F && tk_ff <= 8'h31)))
        else $error("conversion tick count wrong");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_AW_BLOCK: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    COV_END12: cover property ($fell(conv_active) && conv_res12);
    COV_EXT: cover property (ext_ref_pin_en);
    COV_PROBE: cover property (chan_onehot[12]);
endmodule // arp_chk
bind arp_top arp_chk u_arp_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .ref_route(ref_route), .ext_ref_pin_en(ext_ref_pin_en),
    .chan_onehot(chan_onehot), .conv_clk_en(conv_clk_en),
    .conv_active(conv_active), .conv_res12(conv_res12));

// ### test/arp_core_model.sv
// Converter core model returning a fixed sample or a saturation flag.
`timescale 1ns/100ps
module arp_core_model (
    input  wire        aclk,        // System clock.
    input  wire        conv_active, // Conversion running.
    input  wire [1:0]  mode,        // 0 in span, 1 over, 2 under.
    output reg  [11:0] core_result, // Sample value.
    output reg         core_over,   // Above high reference.
    output reg         core_under   // Below low reference.
);
    reg [1:0] hold_ff = 2'h0;
    initial core_result = 12'h000;
    initial core_over = 1'b0;
    initial core_under = 1'b0;
    // Values hold two cycles past the end, then toggle to expose late samples.
    always @(posedge aclk) begin
        hold_ff <= conv_active ? 2'h2 : hold_ff - {1'b0, |hold_ff};
        if (conv_active || |hold_ff) begin
            core_result <= 12'hA5C;
            core_over <= (mode == 2'h1);
            core_under <= (mode == 2'h2);
        end else begin
            core_result <= ~core_result;
            core_over <= ~core_over;
            core_under <= ~core_under;
        end
    end
endmodule // arp_core_model

// ### test/tb.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/100ps
`include "arp_regs.vh"
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0]  mode = 2'h0;
    wire         awready, wready, bvalid, arready, rvalid, ext_pin, clk_en;
    wire         active, res12, over, under;
    wire [1:0]   bresp, rresp, route, p1_off, p2_off;
    wire [31:0]  rdata;
    wire [11:0]  result;
    wire [7:0]   p4_off;
    wire [12:0]  onehot;
    int          fails = 0, tests_run = 0, act_cyc = 0, act_tk = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (active) begin
        act_cyc++;
        act_tk += clk_en;
    end
    arp_top u_arp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_result(result),
        .core_over(over), .core_under(under), .ref_route(route),
        .ext_ref_pin_en(ext_pin), .chan_onehot(onehot), .conv_clk_en(clk_en),
        .conv_active(active), .conv_res12(res12), .p4_dig_off(p4_off),
        .p1_dig_off(p1_off), .p2_dig_off(p2_off));
    arp_core_model u_arp_core_model (.aclk(aclk), .conv_active(active),
        .mode(mode), .core_result(result), .core_over(over),
        .core_under(under));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        // Registered pin outputs follow the register one edge later.
        @(negedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic conv(input logic [1:0] dv, input logic r12,
                        output int len, output int tk);
        int n = 0, c0, t0;
        logic [1:0] rs;
        wr(`ARP_OFF_TIMING, {29'h0, r12, dv}, rs);
        c0 = act_cyc;
        t0 = act_tk;
        wr(`ARP_OFF_CTRL, 32'h40, rs);
        // Settings rewritten mid-conversion must not alter it.
        wr(`ARP_OFF_TIMING, {29'h0, ~r12, ~dv}, rs);
        wr(`ARP_OFF_REFSEL, 32'h01, rs);
        while (active && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        len = act_cyc - c0;
        tk = act_tk - t0;
    endtask
    task automatic t_reset;
        logic [11:0] offs[5] = '{`ARP_OFF_P4CFG, `ARP_OFF_P12CFG,
            `ARP_OFF_REFSEL, `ARP_OFF_CTRL, `ARP_OFF_TIMING};
        logic [31:0] v;
        logic [1:0] rs;
        chk({route, ext_pin, onehot, active, res12, p4_off, p1_off, p2_off}, 0);
        foreach (offs[i]) begin
            rd(offs[i], v, rs);
            chk(v, 32'h0);
        end
    endtask
    task automatic t_ports;
        logic [31:0] v;
        logic [1:0] rs;
        wr(`ARP_OFF_P4CFG, 32'hA5, rs);
        chk(p4_off, 8'hA5);
        rd(`ARP_OFF_P4CFG, v, rs);
        chk(v, 32'h0);
        wr(`ARP_OFF_P12CFG, 32'hFF, rs);
        chk({p1_off, p2_off}, 4'hF);
        wr(`ARP_OFF_P12CFG, 32'h81, rs);
        chk({p1_off, p2_off}, 4'h9);
        wr(`ARP_OFF_P4CFG, 32'h0, rs);
        chk(p4_off, 8'h00);
    endtask
    task automatic t_chan;
        logic [1:0] rs;
        wr(`ARP_OFF_P4CFG, 32'h01, rs);
        wr(`ARP_OFF_REFSEL, 32'h02, rs);
        wr(`ARP_OFF_CTRL, 32'h03, rs);
        chk(onehot, 13'h0);
        for (int c = 0; c < 16; c++) begin
            wr(`ARP_OFF_CTRL, 32'h10 | c, rs);
            chk(onehot, c < 13 ? 13'h1 << c : 13'h0);
        end
        wr(`ARP_OFF_CTRL, 32'h0, rs);
        chk(onehot, 13'h0);
    endtask
    task automatic t_ref;
        int len, tk;
        logic [31:0] v;
        logic [1:0] rs, prev;
        prev = 2'h0;
        for (int c = 0; c < 4; c++) begin
            wr(`ARP_OFF_REFSEL, c, rs);
            chk(route, prev);
            conv(2'h2, 1'b0, len, tk);
            prev = c[1] ? 2'h2 : c[1:0];
            chk(route, prev);
        end
        wr(`ARP_OFF_REFSEL, 32'hFF, rs);
        rd(`ARP_OFF_REFSEL, v, rs);
        chk(v, 32'h83);
        chk(ext_pin, 1'b1);
        wr(`ARP_OFF_CTRL, 32'h10, rs);
        chk(onehot, 13'h0);
        conv(2'h2, 1'b0, len, tk);
        chk(route, 2'h3);
        wr(`ARP_OFF_REFSEL, 32'h02, rs);
        wr(`ARP_OFF_CTRL, 32'h10, rs);
        chk(onehot, 13'h1);
    endtask
    task automatic t_time;
        int len, tk, d, nt;
        logic [31:0] v;
        logic [1:0] rs;
        for (int i = 0; i < 8; i++) begin
            conv(i[1:0], i[2], len, tk);
            d = (i[1:0] == 0) ? 16 : (i[1:0] == 1) ? 8 : (i[1:0] == 2) ? 1 : 2;
            nt = i[2] ? 64 : 48;
            chk(tk >= nt - 1 && tk <= nt + 1, 1);
            chk(len >= nt * d - 3 && len <= nt * d + 3, 1);
            chk(res12, i[2]);
            rd(`ARP_OFF_CTRL, v, rs);
            chk(v & 32'h60, 32'h20);
            rd(`ARP_OFF_RESULT, v, rs);
            chk(v, 32'hA5C);
        end
    endtask
    task automatic t_range;
        int len, tk;
        logic [31:0] v;
        logic [1:0] rs;
        for (int m = 1; m < 3; m++) begin
            mode <= 2'(m);
            conv(2'h3, 1'b1, len, tk);
            rd(`ARP_OFF_RESULT, v, rs);
            chk(v, m == 1 ? 32'hFFF : 32'h0);
        end
        mode <= 2'h0;
    endtask
    task automatic t_bus;
        logic [31:0] v;
        logic [1:0] rs;
        wr(12'h0B0, 32'h80, rs);
        chk(rs, `ARP_RESP_SLVERR);
        chk(ext_pin, 1'b0);
        rd(12'h2D0, v, rs);
        chk(rs, `ARP_RESP_SLVERR);
    endtask
    task results;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #80000;
        fails++;
        results;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_ports;
        t_chan;
        t_ref;
        t_time;
        t_range;
        t_bus;
        results;
    end
endmodule // tb
